// ===== design/sic_consts.svh
`ifndef SIC_CONSTS_SVH
`define SIC_CONSTS_SVH

// clock and timing
`define SIC_CLK_HZ 40000000
`define SIC_TEST_PULSE_NS 400000
`define SIC_TEST_PULSE_CYC ((`SIC_TEST_PULSE_NS / 25) - 1)
`define SIC_TEST_PERIOD_US 100000
`define SIC_TEST_PERIOD_CYC (`SIC_TEST_PERIOD_US * 40)
`define SIC_DRIVE_TIMEOUT_US 200000
`define SIC_DRIVE_TIMEOUT_CYC (`SIC_DRIVE_TIMEOUT_US * 40)
`define SIC_FLASH_HALF_US 250000
`define SIC_FLASH_HALF_CYC (`SIC_FLASH_HALF_US * 40)

// drive attempts before fault
`define SIC_DRIVE_TRIES 2

`endif

// ===== design/sic_pkg.sv
package sic_pkg;
    typedef enum logic [3:0] {
        SIC_INIT = 4'b0000,
        SIC_IDLE = 4'b0001,
        SIC_UNLOCKED = 4'b0010,
        SIC_DRIVE_LOCK = 4'b0011,
        SIC_LOCKED = 4'b0100,
        SIC_DRIVE_UNLOCK = 4'b0101,
        SIC_FAULT = 4'b0110,
        SIC_POR_WAIT_UNLOCK = 4'b0111,
        SIC_AUX_RELEASE = 4'b1000,
        SIC_HOLD_OFF = 4'b1001
    } sic_state_t;
endpackage

// ===== design/sic_pulse_gen.sv
`timescale 1ns/1ps
`include "sic_consts.svh"

// periodic self-test pulse and indicator flash timebase
module sic_pulse_gen #(
    parameter int PERIOD_CYC = `SIC_TEST_PERIOD_CYC,
    parameter int PULSE_CYC = `SIC_TEST_PULSE_CYC,
    parameter int FLASH_CYC = `SIC_FLASH_HALF_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    output logic [1:0] test_off,
    output logic flash
);
    logic [31:0] per_cnt;
    logic [31:0] fl_cnt;
    wire per_wrap = (per_cnt == 32'(PERIOD_CYC - 1));
    wire fl_wrap = (fl_cnt == 32'(FLASH_CYC - 1));
    // channel 0 tested at start of period, channel 1 at half period, so never both at once
    wire ch0_on = (per_cnt < 32'(PULSE_CYC));
    wire ch1_on = (per_cnt >= 32'(PERIOD_CYC / 2)) && (per_cnt < 32'(PERIOD_CYC / 2 + PULSE_CYC));

    // free-running period counter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            per_cnt <= 32'h0;
            test_off <= 2'h0;
        end else begin
            per_cnt <= per_wrap ? 32'h0 : per_cnt + 32'h1;
            test_off <= {ch1_on, ch0_on};
        end
    end

    // indicator flash toggle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fl_cnt <= 32'h0;
            flash <= 1'b0;
        end else begin
            fl_cnt <= fl_wrap ? 32'h0 : fl_cnt + 32'h1;
            if (fl_wrap) begin
                flash <= ~flash;
            end
        end
    end

    // pulse width is registered once, so off time is PULSE_CYC cycles
    int pw;
    always_ff @(posedge clk) begin
        if (!rstn || !test_off[0]) begin
            pw <= 0;
        end else begin
            pw <= pw + 1;
        end
    end
    AST_PULSE_MAX: assert property (@(posedge clk) disable iff (!rstn) test_off[0] |-> pw <= PULSE_CYC)
        else $error("test pulse too long");
    AST_NOT_BOTH: assert property (@(posedge clk) disable iff (!rstn) !(test_off[0] && test_off[1]))
        else $error("both channels tested together");
    COV_PULSE: cover property (@(posedge clk) disable iff (!rstn) $rose(test_off[1]));
endmodule

// ===== design/sic_ctrl.sv
`timescale 1ns/1ps
`include "sic_consts.svh"

// Notes on behaviour
// - no supplies at init: hold bolt, outputs off
// - main only at init: follow control inputs
// - aux only at init: retract bolt, unlock
// - both supplies at init: hold bolt, fault
// - supply table used only while initialising
// - aux release: safety outputs, diagnostics off
// - aux release ignores control inputs
// - unlock on unlock pattern, else lock
// - same decode for both variants
// - failed lock drive retried once
// - second failure raises fault
// - after fault, wait for input change
// - locked at power-on needs unlock then lock
// - yellow flashes while awaiting that cycle
// - emergency exit turns both outputs off
// - emergency exit blocks any locking
// - test pulses each output, at most 0.4 ms
// - returned manual release: flash all indicators
module sic_ctrl #(
    parameter int DRIVE_TIMEOUT_CYC = `SIC_DRIVE_TIMEOUT_CYC,
    parameter int TEST_PERIOD_CYC = `SIC_TEST_PERIOD_CYC,
    parameter int FLASH_HALF_CYC = `SIC_FLASH_HALF_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic main_supply_ok,
    input wire logic aux_release_supply,
    input wire logic aux_release_variant,
    input wire logic push_pull_wiring,
    input wire logic lock_ctrl_in_a,
    input wire logic lock_ctrl_in_b,
    input wire logic lock_ctrl_in_ref,
    input wire logic bolt_locked,
    input wire logic bolt_unlocked,
    input wire logic actuator_present,
    input wire logic emergency_exit,
    input wire logic manual_release_returned,
    output logic drive_extend,
    output logic drive_retract,
    output logic [1:0] switching_safety_output,
    output logic diag_out,
    output logic led_green,
    output logic led_yellow,
    output logic led_red,
    output logic fault
);
    sic_pkg::sic_state_t state;
    sic_pkg::sic_state_t next_state;
    logic [31:0] drv_cnt;
    logic [1:0] tries;
    logic [2:0] in_snap;
    logic mrel_flag;
    logic [1:0] test_off;
    logic flash;

    // both wiring styles share one decode; variant pin never enters it
    wire [2:0] in_now = {lock_ctrl_in_a, lock_ctrl_in_b, lock_ctrl_in_ref};
    wire pp_unlock = lock_ctrl_in_a && lock_ctrl_in_b && !lock_ctrl_in_ref;
    wire pn_unlock = lock_ctrl_in_a && lock_ctrl_in_b && !lock_ctrl_in_ref;
    wire want_unlock = push_pull_wiring ? pn_unlock : pp_unlock;
    wire in_changed = (in_now != in_snap);
    wire drv_timeout = (drv_cnt == 32'(DRIVE_TIMEOUT_CYC - 1));
    wire aux_only = aux_release_variant && aux_release_supply && !main_supply_ok;
    // emergency exit overrides every lock request
    wire lock_ok = !want_unlock && !emergency_exit;

    sic_pulse_gen #(
        .PERIOD_CYC(TEST_PERIOD_CYC),
        .PULSE_CYC(`SIC_TEST_PULSE_CYC),
        .FLASH_CYC(FLASH_HALF_CYC)
    ) u_pulse (
        .clk(clk),
        .rstn(rstn),
        .test_off(test_off),
        .flash(flash)
    );

    // next state; supply table only consulted from SIC_INIT
    always_comb begin
        next_state = state;
        case (state)
            sic_pkg::SIC_INIT: begin
                if (aux_release_variant && aux_release_supply && main_supply_ok) begin
                    next_state = sic_pkg::SIC_FAULT;
                end else if (aux_only) begin
                    next_state = sic_pkg::SIC_AUX_RELEASE;
                end else if (!main_supply_ok) begin
                    next_state = sic_pkg::SIC_HOLD_OFF;
                end else if (bolt_locked) begin
                    next_state = sic_pkg::SIC_POR_WAIT_UNLOCK;
                end else begin
                    next_state = sic_pkg::SIC_IDLE;
                end
            end
            sic_pkg::SIC_HOLD_OFF: begin
                // basic variant has no aux input, so aux alone must not wake it or it would spin through init
                if (main_supply_ok || (aux_release_variant && aux_release_supply)) begin
                    next_state = sic_pkg::SIC_INIT;
                end
            end
            sic_pkg::SIC_AUX_RELEASE: begin
                // stays released until power cycle
                next_state = sic_pkg::SIC_AUX_RELEASE;
            end
            sic_pkg::SIC_POR_WAIT_UNLOCK: begin
                if (want_unlock) begin
                    next_state = sic_pkg::SIC_DRIVE_UNLOCK;
                end
            end
            sic_pkg::SIC_IDLE: begin
                if (want_unlock) begin
                    next_state = sic_pkg::SIC_DRIVE_UNLOCK;
                end else if (lock_ok) begin
                    next_state = sic_pkg::SIC_DRIVE_LOCK;
                end
            end
            sic_pkg::SIC_UNLOCKED: begin
                if (lock_ok) begin
                    next_state = sic_pkg::SIC_DRIVE_LOCK;
                end
            end
            sic_pkg::SIC_DRIVE_LOCK: begin
                if (want_unlock || emergency_exit) begin
                    next_state = sic_pkg::SIC_DRIVE_UNLOCK;
                end else if (bolt_locked) begin
                    next_state = sic_pkg::SIC_LOCKED;
                end else if (drv_timeout && tries == 2'(`SIC_DRIVE_TRIES - 1)) begin
                    next_state = sic_pkg::SIC_FAULT;
                end
            end
            sic_pkg::SIC_LOCKED: begin
                if (want_unlock || emergency_exit || !bolt_locked) begin
                    next_state = sic_pkg::SIC_DRIVE_UNLOCK;
                end
            end
            sic_pkg::SIC_DRIVE_UNLOCK: begin
                if (bolt_unlocked) begin
                    next_state = sic_pkg::SIC_UNLOCKED;
                end
            end
            sic_pkg::SIC_FAULT: begin
                if (in_changed && main_supply_ok && !aux_release_supply) begin
                    next_state = want_unlock ? sic_pkg::SIC_DRIVE_UNLOCK : sic_pkg::SIC_UNLOCKED;
                end
            end
            default: next_state = sic_pkg::SIC_INIT;
        endcase
    end

    // state, retry and drive timer registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= sic_pkg::SIC_INIT;
            tries <= 2'h0;
            drv_cnt <= 32'h0;
        end else begin
            state <= next_state;
            if (next_state != sic_pkg::SIC_DRIVE_LOCK || state != sic_pkg::SIC_DRIVE_LOCK) begin
                drv_cnt <= 32'h0;
                tries <= 2'h0;
            end else if (drv_timeout) begin
                drv_cnt <= 32'h0;
                tries <= tries + 2'h1;
            end else begin
                drv_cnt <= drv_cnt + 32'h1;
            end
        end
    end

    // input pattern frozen on fault entry, compared while faulted
    always_ff @(posedge clk) begin
        if (!rstn) begin
            in_snap <= 3'h0;
        end else if (state != sic_pkg::SIC_FAULT) begin
            in_snap <= in_now;
        end
    end

    // returned manual release flag, set wins over clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mrel_flag <= 1'b0;
        end else if (manual_release_returned) begin
            mrel_flag <= 1'b1;
        end else if (in_changed) begin
            mrel_flag <= 1'b0;
        end
    end

    // state qualifiers for the outputs
    wire sso_en = (state == sic_pkg::SIC_LOCKED) && bolt_locked && actuator_present && !emergency_exit;
    wire aux_mode = (state == sic_pkg::SIC_AUX_RELEASE);
    wire faulted = (state == sic_pkg::SIC_FAULT);
    wire por_wait = (state == sic_pkg::SIC_POR_WAIT_UNLOCK);
    wire next_extend = (next_state == sic_pkg::SIC_DRIVE_LOCK);
    wire next_retract = (next_state == sic_pkg::SIC_DRIVE_UNLOCK) || (next_state == sic_pkg::SIC_AUX_RELEASE);

    // output next values; safety outputs only ever leave LOCKED switched off
    wire [1:0] next_sso = sso_en ? ~test_off : 2'h0;
    wire next_diag = !aux_mode && sso_en;
    wire next_green = mrel_flag ? flash : (!aux_mode && main_supply_ok);
    // yellow flashes while the power-on unlock-lock cycle is pending
    wire next_yellow = mrel_flag ? flash : (por_wait ? flash : sso_en);
    wire next_red = mrel_flag ? flash : faulted;

    // all outputs registered
    always_ff @(posedge clk) begin
        if (!rstn) begin
            drive_extend <= 1'b0;
            drive_retract <= 1'b0;
            switching_safety_output <= 2'h0;
            diag_out <= 1'b0;
            led_green <= 1'b0;
            led_yellow <= 1'b0;
            led_red <= 1'b0;
            fault <= 1'b0;
        end else begin
            drive_extend <= next_extend && !emergency_exit;
            drive_retract <= next_retract;
            switching_safety_output <= next_sso;
            diag_out <= next_diag;
            led_green <= next_green;
            led_yellow <= next_yellow;
            led_red <= next_red;
            fault <= faulted;
        end
    end

    // emergency exit, aux release, supply, decode, retry, fault hold and flash checks
    AST_EXIT_OFF: assert property (@(posedge clk) disable iff (!rstn)
        emergency_exit |=> switching_safety_output == 2'h0)
        else $error("outputs on during emergency exit");
    AST_EXIT_NO_LOCK: assert property (@(posedge clk) disable iff (!rstn)
        emergency_exit |=> !drive_extend)
        else $error("lock drive during emergency exit");
    AST_AUX_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_AUX_RELEASE |=> drive_retract && switching_safety_output == 2'h0 && !diag_out)
        else $error("aux release not retracting or outputs on");
    AST_BOTH_SUPPLY: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_INIT && main_supply_ok && aux_release_supply && aux_release_variant
        |=> ##1 fault)
        else $error("both supplies did not fault");
    AST_NO_SUPPLY: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_HOLD_OFF |=> !drive_extend && switching_safety_output == 2'h0)
        else $error("bolt moved with no supply");
    AST_UNLOCK_DECODE: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_LOCKED && want_unlock |=> state == sic_pkg::SIC_DRIVE_UNLOCK)
        else $error("unlock pattern ignored");
    AST_RETRY: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_DRIVE_LOCK && drv_timeout && tries == 2'h0 && !bolt_locked && lock_ok
        |=> state == sic_pkg::SIC_DRIVE_LOCK && tries == 2'h1)
        else $error("no second lock attempt");
    AST_FAULT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        faulted && !in_changed |=> faulted)
        else $error("fault left without input change");
    AST_POR_FLASH: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_POR_WAIT_UNLOCK && !mrel_flag |=> led_yellow == $past(flash))
        else $error("yellow not flashing after locked power-on");
    AST_SSO_GATE: assert property (@(posedge clk) disable iff (!rstn)
        !sso_en |=> switching_safety_output == 2'h0)
        else $error("outputs on while not locked");
    // start-up supply table and its limits
    AST_MAIN_ONLY: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_INIT && main_supply_ok && !aux_release_supply && !bolt_locked
        |=> state == sic_pkg::SIC_IDLE)
        else $error("main supply alone did not follow inputs");
    AST_AUX_ONLY: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_INIT && aux_only |=> state == sic_pkg::SIC_AUX_RELEASE)
        else $error("aux supply alone did not release");
    AST_INIT_ONCE: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_INIT |=> state != sic_pkg::SIC_INIT)
        else $error("supply table evaluated twice");
    AST_TABLE_INIT_ONLY: assert property (@(posedge clk) disable iff (!rstn)
        state != sic_pkg::SIC_INIT && state != sic_pkg::SIC_AUX_RELEASE
        |=> state != sic_pkg::SIC_AUX_RELEASE)
        else $error("aux release entered outside init");
    AST_AUX_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_AUX_RELEASE |=> state == sic_pkg::SIC_AUX_RELEASE)
        else $error("aux release left on input change");
    // drive sequencing, fault refusal and manual release flash
    AST_LOCK_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_UNLOCKED && lock_ok |=> drive_extend)
        else $error("lock pattern did not drive bolt out");
    AST_SECOND_FAIL: assert property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_DRIVE_LOCK && drv_timeout && tries == 2'h1 && !bolt_locked && lock_ok
        |=> faulted)
        else $error("second failed attempt gave no fault");
    AST_FAULT_NO_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
        faulted |=> !drive_extend)
        else $error("bolt driven out while faulted");
    AST_MREL_FLASH: assert property (@(posedge clk) disable iff (!rstn)
        mrel_flag |=> led_red == $past(flash) && led_green == $past(flash))
        else $error("indicators not flashing after manual release");
    COV_LOCK: cover property (@(posedge clk) disable iff (!rstn) state == sic_pkg::SIC_LOCKED);
    COV_FAULT: cover property (@(posedge clk) disable iff (!rstn) $rose(fault));
    COV_POR: cover property (@(posedge clk) disable iff (!rstn)
        state == sic_pkg::SIC_POR_WAIT_UNLOCK ##1 state == sic_pkg::SIC_DRIVE_UNLOCK);
    COV_AUX: cover property (@(posedge clk) disable iff (!rstn) state == sic_pkg::SIC_AUX_RELEASE);
endmodule

// ===== verif/sic_bolt_model.sv
`timescale 1ns/1ps

// bolt mechanics: travel takes TRAVEL cycles each way
module sic_bolt_model #(
    parameter int TRAVEL = 4
) (
    input wire logic clk,
    input wire logic drive_extend,
    input wire logic drive_retract,
    input wire logic jam,
    input wire logic emergency_exit,
    input wire logic preset,
    input wire logic preset_locked,
    output logic bolt_locked,
    output logic bolt_unlocked
);
    int pos = 0;

    // a jam stalls the extend so the lock drive must time out
    always @(posedge clk) begin
        if (preset) begin
            pos <= preset_locked ? TRAVEL : 0;
        end else if (emergency_exit) begin
            pos <= 0; // spring force, no drive needed
        end else if (drive_extend && !jam && pos < TRAVEL) begin
            pos <= pos + 1;
        end else if (drive_retract && pos > 0) begin
            pos <= pos - 1;
        end
    end

    // end-position sensors only
    assign bolt_locked = (pos == TRAVEL);
    assign bolt_unlocked = (pos == 0);
endmodule

// ===== verif/solenoid_interlock_control_test.sv
`timescale 1ns/1ps

module solenoid_interlock_control_test;
    logic clk, rstn, main_supply_ok, aux_release_supply, aux_release_variant, push_pull_wiring;
    logic lock_ctrl_in_a, lock_ctrl_in_b, lock_ctrl_in_ref, bolt_locked, bolt_unlocked;
    logic actuator_present, emergency_exit, drive_extend, drive_retract, diag_out;
    logic led_green, led_yellow, led_red, fault, jam, preset, preset_locked, manual_release_returned;
    logic [1:0] switching_safety_output;
    int error_cnt = 0;
    int samples_checked = 0;

    sic_ctrl #(.DRIVE_TIMEOUT_CYC(50), .TEST_PERIOD_CYC(40000), .FLASH_HALF_CYC(8)) uut (
        .clk(clk), .rstn(rstn), .main_supply_ok(main_supply_ok), .aux_release_supply(aux_release_supply),
        .aux_release_variant(aux_release_variant), .push_pull_wiring(push_pull_wiring),
        .lock_ctrl_in_a(lock_ctrl_in_a), .lock_ctrl_in_b(lock_ctrl_in_b), .lock_ctrl_in_ref(lock_ctrl_in_ref),
        .bolt_locked(bolt_locked), .bolt_unlocked(bolt_unlocked), .actuator_present(actuator_present),
        .emergency_exit(emergency_exit), .manual_release_returned(manual_release_returned),
        .drive_extend(drive_extend),
        .drive_retract(drive_retract), .switching_safety_output(switching_safety_output),
        .diag_out(diag_out), .led_green(led_green), .led_yellow(led_yellow), .led_red(led_red), .fault(fault));

    sic_bolt_model #(.TRAVEL(4)) bolt (
        .clk(clk), .drive_extend(drive_extend), .drive_retract(drive_retract), .jam(jam),
        .emergency_exit(emergency_exit), .preset(preset), .preset_locked(preset_locked),
        .bolt_locked(bolt_locked), .bolt_unlocked(bolt_unlocked));

    // 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic got, input logic exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic chk2(input logic [1:0] got, input logic [1:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    // after time 0, inputs move 2 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic set_in(input logic a, input logic b, input logic r);
        lock_ctrl_in_a = a;
        lock_ctrl_in_b = b;
        lock_ctrl_in_ref = r;
    endtask

    // supplies and bolt position settle while reset is held
    task automatic boot(input logic main, input logic aux, input logic vrt, input logic locked);
        cyc(1);
        rstn = 1'b0;
        main_supply_ok = main;
        aux_release_supply = aux;
        aux_release_variant = vrt;
        emergency_exit = 1'b0;
        jam = 1'b0;
        preset = 1'b1;
        preset_locked = locked;
        cyc(20);
        preset = 1'b0;
        rstn = 1'b1;
        cyc(2);
    endtask

    task automatic wait_pos(input logic want_locked, input int lim, input string msg);
        for (int i = 0; i < lim; i++) begin
            if ((want_locked ? bolt_locked : bolt_unlocked) === 1'b1) return;
            cyc(1);
        end
        chk(1'b0, 1'b1, msg);
    endtask

    // normal lock and unlock, outputs and test pulse
    task automatic s_lock_unlock;
        int n;
        logic both_low;
        set_in(1'b1, 1'b1, 1'b0);
        boot(1'b1, 1'b0, 1'b0, 1'b0);
        cyc(10);
        chk(bolt_unlocked, 1'b1, "unlock pattern did not keep bolt in");
        set_in(1'b0, 1'b0, 1'b0);
        wait_pos(1'b1, 60, "bolt never locked");
        cyc(3);
        chk(diag_out, 1'b1, "outputs not enabled when locked");
        // channel 1 pulse sits at half period, so it is seen whole; channel 0 is mid-pulse here
        n = 0;
        while (switching_safety_output[1] !== 1'b0 && n < 41000) begin
            cyc(1);
            n++;
        end
        n = 0;
        both_low = 1'b0;
        while (switching_safety_output[1] === 1'b0 && n < 41000) begin
            if (switching_safety_output[0] !== 1'b1) both_low = 1'b1;
            cyc(1);
            n++;
        end
        chk(n > 0 && n <= 16000, 1'b1, "test pulse missing or too long");
        chk(n < 40000, 1'b1, "test pulse too long to blank");
        chk(both_low, 1'b0, "both channels off together");
        chk2(switching_safety_output, 2'b11, "outputs not both on after pulse");
        push_pull_wiring = 1'b1;
        set_in(1'b1, 1'b1, 1'b0);
        wait_pos(1'b0, 60, "no unlock with second wiring");
        cyc(2);
        chk2(switching_safety_output, 2'b00, "outputs on while unlocked");
        push_pull_wiring = 1'b0;
    endtask

    // blocked drive, retry, fault, refusal until input change
    task automatic s_jam;
        int n;
        set_in(1'b1, 1'b1, 1'b0);
        boot(1'b1, 1'b0, 1'b0, 1'b0);
        jam = 1'b1;
        set_in(1'b1, 1'b0, 1'b0);
        n = 0;
        while (fault !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        chk(n >= 100 && n < 300, 1'b1, "fault not after second attempt");
        chk(fault, 1'b1, "no fault after two attempts");
        jam = 1'b0;
        cyc(60);
        chk(drive_extend, 1'b0, "drive resumed without input change");
        set_in(1'b0, 1'b0, 1'b0);
        wait_pos(1'b1, 120, "lock not accepted after input change");
        chk(fault, 1'b0, "fault held after input change");
        cyc(3);
        chk(diag_out, 1'b1, "outputs not on before emergency exit");
        emergency_exit = 1'b1;
        cyc(3);
        chk2(switching_safety_output, 2'b00, "outputs on at emergency exit");
        chk(diag_out, 1'b0, "diagnostics on at emergency exit");
        cyc(20);
        chk(bolt_locked, 1'b0, "locked during emergency exit");
        emergency_exit = 1'b0;
    endtask

    // supply combinations at start-up
    task automatic s_supplies;
        set_in(1'b0, 1'b0, 1'b0);
        boot(1'b0, 1'b1, 1'b1, 1'b1);
        wait_pos(1'b0, 60, "aux supply did not retract");
        chk(diag_out, 1'b0, "diagnostics on in aux release");
        set_in(1'b1, 1'b1, 1'b0);
        cyc(20);
        chk2(switching_safety_output, 2'b00, "outputs on in aux release");
        boot(1'b1, 1'b1, 1'b1, 1'b0);
        cyc(5);
        chk(fault, 1'b1, "both supplies gave no fault");
        chk(drive_retract, 1'b0, "bolt moved with both supplies");
        set_in(1'b0, 1'b0, 1'b0);
        boot(1'b0, 1'b0, 1'b1, 1'b1);
        cyc(10);
        chk(bolt_locked, 1'b1, "bolt moved without supplies");
        chk2(switching_safety_output, 2'b00, "outputs on without supplies");
    endtask

    // locked at power-on needs an unlock-lock cycle
    task automatic s_por_locked;
        int t;
        logic last;
        set_in(1'b0, 1'b0, 1'b0);
        boot(1'b1, 1'b0, 1'b0, 1'b1);
        t = 0;
        last = led_yellow;
        for (int i = 0; i < 40; i++) begin
            cyc(1);
            if (led_yellow !== last) t++;
            last = led_yellow;
        end
        chk(t >= 2, 1'b1, "yellow not flashing");
        chk(diag_out, 1'b0, "locked operation accepted too early");
        set_in(1'b1, 1'b1, 1'b0);
        wait_pos(1'b0, 60, "no unlock in power-on cycle");
        set_in(1'b0, 1'b0, 1'b0);
        wait_pos(1'b1, 60, "no relock in power-on cycle");
        cyc(3);
        chk(diag_out, 1'b1, "locked operation not accepted");
    endtask

    // returned manual release flashes all indicators until inputs move again
    task automatic s_manual;
        int t;
        logic same;
        logic last;
        manual_release_returned = 1'b1;
        cyc(1);
        manual_release_returned = 1'b0;
        cyc(2);
        t = 0;
        same = 1'b1;
        last = led_red;
        for (int i = 0; i < 40; i++) begin
            cyc(1);
            if (led_green !== led_red || led_yellow !== led_red) same = 1'b0;
            if (led_red !== last) t++;
            last = led_red;
        end
        chk(same, 1'b1, "indicators not flashing together");
        chk(t >= 2, 1'b1, "indicators not flashing");
        set_in(1'b1, 1'b0, 1'b0);
        cyc(3);
        chk(led_red, 1'b0, "flash kept after inputs driven");
        chk(led_yellow, 1'b1, "yellow not back to locked");
    endtask

    task automatic results;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        main_supply_ok = 1'b0;
        aux_release_supply = 1'b0;
        aux_release_variant = 1'b0;
        push_pull_wiring = 1'b0;
        actuator_present = 1'b1;
        emergency_exit = 1'b0;
        jam = 1'b0;
        preset = 1'b1;
        preset_locked = 1'b0;
        manual_release_returned = 1'b0;
        set_in(1'b0, 1'b0, 1'b0);
        s_lock_unlock();
        s_jam();
        s_supplies();
        s_por_locked();
        s_manual();
        results();
    end

    // runaway guard, well past the expected span
    initial begin
        #(25 * 95000);
        error_cnt++;
        results();
    end
endmodule
